// [core/ssc_top.sv]
// command decoder for status reads and sleep control
// Contract
// - 0Dh reads dummy then image-mode byte
// - image byte bit 7 shows scrolling
// - image and signal bytes zero after resets
// - 0Eh reads dummy then signal byte
// - signal byte shows tear enable and mode
// - 0Fh reads dummy then diagnostic byte
// - healthy diagnostic reads alternate inverted
// - 10h enters minimum-power sleep
// - sleep stops pump, oscillator, scanning
// - sleep-in while sleeping does nothing
// - 11h restarts pump, oscillator, scanning
// - sleep-out while awake is ignored
// - self-diagnostic runs during 5 ms wake
// - factory defaults loaded within 120 ms
// - awake left only by resets, sleep-in, event
// - inversion inverts display data, not memory
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"

module ssc_top #(
  parameter int unsigned SETTLE_CYCLES = `SSC_SETTLE_CYCLES,
  parameter int unsigned LOAD_CYCLES = `SSC_LOAD_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // host command pins
  input wire logic command_param_select,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  // state from other display logic
  input wire logic scroll_active,
  input wire logic inversion_active,
  input wire logic tear_output_enabled,
  input wire logic tear_output_mode,
  input wire logic diag_healthy,
  input wire logic nmi_event,
  // power control
  output logic charge_pump_en,
  output logic osc_en,
  output logic scan_en,
  output logic sleeping,
  output logic diag_running,
  output logic defaults_load,
  output logic soft_reset_pulse,
  // display data path
  input wire logic [17:0] mem_pixel,
  output logic [17:0] disp_pixel
);

  localparam logic [`SSC_TIMER_W-1:0] SETTLE_LAST = `SSC_TIMER_W'(SETTLE_CYCLES - 1);
  localparam logic [`SSC_TIMER_W-1:0] LOAD_LAST = `SSC_TIMER_W'(LOAD_CYCLES - SETTLE_CYCLES - 1);

  // pin synchronisers, first stage feeds only the second
  logic [10:0] pin_meta_reg;
  logic [10:0] pin_sync_reg;
  logic rd_n_dly_reg;
  logic wr_n_dly_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 11'h7FF;
      pin_sync_reg <= 11'h7FF;
      rd_n_dly_reg <= 1'b1;
      wr_n_dly_reg <= 1'b1;
    end else begin
      pin_meta_reg <= {command_param_select, read_strobe_n, write_strobe_n, host_data_in};
      pin_sync_reg <= pin_meta_reg;
      rd_n_dly_reg <= pin_sync_reg[9];
      wr_n_dly_reg <= pin_sync_reg[8];
    end
  end

  logic sel_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [7:0] data_s;
  logic rd_start;
  logic rd_end;
  logic wr_end;
  logic cmd_write;

  assign sel_s = pin_sync_reg[10];
  assign rd_n_s = pin_sync_reg[9];
  assign wr_n_s = pin_sync_reg[8];
  assign data_s = pin_sync_reg[7:0];
  assign rd_start = rd_n_dly_reg && !rd_n_s;
  assign rd_end = !rd_n_dly_reg && rd_n_s;
  assign wr_end = !wr_n_dly_reg && wr_n_s;
  assign cmd_write = wr_end && !sel_s;

  // decoded command pulses
  logic sw_reset_cmd;
  logic enter_sleep_cmd;
  logic leave_sleep_cmd;

  assign sw_reset_cmd = cmd_write && (data_s == `SSC_CMD_SOFT_RESET);
  assign enter_sleep_cmd = cmd_write && (data_s == `SSC_CMD_ENTER_SLEEP);
  assign leave_sleep_cmd = cmd_write && (data_s == `SSC_CMD_LEAVE_SLEEP);

  // status bytes
  logic [7:0] image_mode_status_reg;
  logic [7:0] image_mode_status_next;
  logic [7:0] signal_mode_status_reg;
  logic [7:0] signal_mode_status_next;
  logic [`SSC_DIAG_FIELD_W-1:0] diagnostic_result_field;
  logic [7:0] self_diagnostic_result;

  always_comb begin
    image_mode_status_next = `SSC_IMAGE_MODE_RST;
    signal_mode_status_next = `SSC_SIGNAL_MODE_RST;
    if (!sw_reset_cmd) begin
      image_mode_status_next[`SSC_IMG_SCROLL_BIT] = scroll_active;
      image_mode_status_next[`SSC_IMG_INVERT_BIT] = inversion_active;
      signal_mode_status_next[`SSC_SIG_TEAR_ON_BIT] = tear_output_enabled;
      signal_mode_status_next[`SSC_SIG_TEAR_MODE_BIT] = tear_output_mode;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      image_mode_status_reg <= `SSC_IMAGE_MODE_RST;
      signal_mode_status_reg <= `SSC_SIGNAL_MODE_RST;
    end else begin
      image_mode_status_reg <= image_mode_status_next;
      signal_mode_status_reg <= signal_mode_status_next;
    end
  end

  assign self_diagnostic_result = {diagnostic_result_field, 4'h0};

  // read sequencer
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  ssc_pkg::ssc_rd_phase_t rd_phase_reg;
  ssc_pkg::ssc_rd_phase_t rd_phase_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic diag_read_done;
  logic [7:0] status_sel;

  always_comb begin
    case (cmd_reg)
      `SSC_CMD_READ_IMAGE_MODE: status_sel = image_mode_status_reg;
      `SSC_CMD_READ_SIGNAL_MODE: status_sel = signal_mode_status_reg;
      `SSC_CMD_READ_DIAGNOSTIC_RESULT_FIELD: status_sel = self_diagnostic_result;
      default: status_sel = `SSC_DUMMY_BYTE;
    endcase
  end

  always_comb begin
    cmd_next = cmd_reg;
    rd_phase_next = rd_phase_reg;
    rd_data_next = rd_data_reg;
    diag_read_done = 1'b0;
    if (cmd_write) begin
      cmd_next = data_s;
      rd_phase_next = ssc_pkg::SSC_RD_DUMMY;
    end else if (rd_start && sel_s) begin
      case (rd_phase_reg)
        ssc_pkg::SSC_RD_DUMMY: rd_data_next = `SSC_DUMMY_BYTE;
        ssc_pkg::SSC_RD_STATUS: rd_data_next = status_sel;
        ssc_pkg::SSC_RD_DONE: rd_data_next = `SSC_DUMMY_BYTE;
        default: rd_data_next = `SSC_DUMMY_BYTE;
      endcase
    end else if (rd_end && sel_s) begin
      case (rd_phase_reg)
        ssc_pkg::SSC_RD_DUMMY: rd_phase_next = ssc_pkg::SSC_RD_STATUS;
        ssc_pkg::SSC_RD_STATUS: begin
          rd_phase_next = ssc_pkg::SSC_RD_DONE;
          diag_read_done = (cmd_reg == `SSC_CMD_READ_DIAGNOSTIC_RESULT_FIELD);
        end
        ssc_pkg::SSC_RD_DONE: rd_phase_next = ssc_pkg::SSC_RD_DONE;
        default: rd_phase_next = ssc_pkg::SSC_RD_DONE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= 8'h00;
      rd_phase_reg <= ssc_pkg::SSC_RD_DONE;
      rd_data_reg <= `SSC_DUMMY_BYTE;
    end else begin
      cmd_reg <= cmd_next;
      rd_phase_reg <= rd_phase_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign host_data_out = rd_data_reg;
  assign host_data_oe = !rd_n_s && sel_s;

  ssc_diag u_diag (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .soft_clear(sw_reset_cmd),
    .read_done(diag_read_done),
    .healthy(diag_healthy),
    .diagnostic_result_field(diagnostic_result_field)
  );

  // power state machine
  ssc_pkg::ssc_pwr_state_t pwr_reg;
  ssc_pkg::ssc_pwr_state_t pwr_next;
  logic [`SSC_TIMER_W-1:0] timer_reg;
  logic [`SSC_TIMER_W-1:0] timer_next;
  logic load_pulse_reg;
  logic load_pulse_next;
  logic soft_reset_reg;
  logic soft_reset_next;

  always_comb begin
    pwr_next = pwr_reg;
    timer_next = timer_reg + `SSC_TIMER_W'(1);
    load_pulse_next = 1'b0;
    soft_reset_next = sw_reset_cmd;
    if (sw_reset_cmd || nmi_event) begin
      pwr_next = ssc_pkg::SSC_PWR_SLEEP;
      timer_next = '0;
    end else begin
      case (pwr_reg)
        ssc_pkg::SSC_PWR_SLEEP: begin
          timer_next = '0;
          if (leave_sleep_cmd) begin
            pwr_next = ssc_pkg::SSC_PWR_DIAG;
          end
        end
        ssc_pkg::SSC_PWR_ENTERING: begin
          if (leave_sleep_cmd) begin
            pwr_next = ssc_pkg::SSC_PWR_DIAG;
            timer_next = '0;
          end else if (timer_reg == SETTLE_LAST) begin
            pwr_next = ssc_pkg::SSC_PWR_SLEEP;
          end
        end
        ssc_pkg::SSC_PWR_DIAG: begin
          if (enter_sleep_cmd) begin
            pwr_next = ssc_pkg::SSC_PWR_ENTERING;
            timer_next = '0;
          end else if (timer_reg == SETTLE_LAST) begin
            pwr_next = ssc_pkg::SSC_PWR_LOADING;
            timer_next = '0;
            load_pulse_next = 1'b1;
          end
        end
        ssc_pkg::SSC_PWR_LOADING: begin
          if (enter_sleep_cmd) begin
            pwr_next = ssc_pkg::SSC_PWR_ENTERING;
            timer_next = '0;
          end else if (timer_reg == LOAD_LAST) begin
            pwr_next = ssc_pkg::SSC_PWR_AWAKE;
          end
        end
        ssc_pkg::SSC_PWR_AWAKE: begin
          timer_next = '0;
          if (enter_sleep_cmd) begin
            pwr_next = ssc_pkg::SSC_PWR_ENTERING;
          end
        end
        default: begin
          pwr_next = ssc_pkg::SSC_PWR_SLEEP;
          timer_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= ssc_pkg::SSC_PWR_SLEEP;
      timer_reg <= '0;
      load_pulse_reg <= 1'b0;
      soft_reset_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      timer_reg <= timer_next;
      load_pulse_reg <= load_pulse_next;
      soft_reset_reg <= soft_reset_next;
    end
  end

  // power outputs, sleep-in/out in the wrong state falls through above
  logic run_reg;
  logic run_next;
  logic [17:0] pixel_reg;
  logic [17:0] pixel_next;

  always_comb begin
    run_next = (pwr_next != ssc_pkg::SSC_PWR_SLEEP) && (pwr_next != ssc_pkg::SSC_PWR_ENTERING);
    pixel_next = inversion_active ? ~mem_pixel : mem_pixel;
    if (!run_next) begin
      pixel_next = 18'h00000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 1'b0;
      pixel_reg <= 18'h00000;
    end else begin
      run_reg <= run_next;
      pixel_reg <= pixel_next;
    end
  end

  assign charge_pump_en = run_reg;
  assign osc_en = run_reg;
  assign scan_en = run_reg;
  assign sleeping = !run_reg;
  assign diag_running = (pwr_reg == ssc_pkg::SSC_PWR_DIAG);
  assign defaults_load = load_pulse_reg;
  assign soft_reset_pulse = soft_reset_reg;
  assign disp_pixel = pixel_reg;

endmodule

`default_nettype wire

// [core/ssc_params.svh]
// constants for the status read and sleep control block
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// command codes
`define SSC_CMD_SOFT_RESET 8'h01
`define SSC_CMD_READ_IMAGE_MODE 8'h0D
`define SSC_CMD_READ_SIGNAL_MODE 8'h0E
`define SSC_CMD_READ_DIAGNOSTIC_RESULT_FIELD 8'h0F
`define SSC_CMD_ENTER_SLEEP 8'h10
`define SSC_CMD_LEAVE_SLEEP 8'h11

// status byte fields
`define SSC_IMG_SCROLL_BIT 7
`define SSC_IMG_INVERT_BIT 5
`define SSC_SIG_TEAR_ON_BIT 7
`define SSC_SIG_TEAR_MODE_BIT 6
`define SSC_DIAG_FIELD_LSB 4
`define SSC_DIAG_FIELD_W 4

// reset values
`define SSC_IMAGE_MODE_RST 8'h00
`define SSC_SIGNAL_MODE_RST 8'h00
`define SSC_DIAG_RST 4'h0
`define SSC_DUMMY_BYTE 8'h00

// timing
`define SSC_CLK_PERIOD_NS 8
`define SSC_SETTLE_TIME_NS 5000000
`define SSC_LOAD_TIME_NS 120000000
`define SSC_SETTLE_CYCLES ((`SSC_SETTLE_TIME_NS + `SSC_CLK_PERIOD_NS - 1) / `SSC_CLK_PERIOD_NS)
`define SSC_LOAD_CYCLES ((`SSC_LOAD_TIME_NS + `SSC_CLK_PERIOD_NS - 1) / `SSC_CLK_PERIOD_NS)
`define SSC_TIMER_W 24

`endif

// [core/ssc_pkg.sv]
// types for the status read and sleep control block
`default_nettype none
package ssc_pkg;

  typedef enum logic [2:0] {
    SSC_PWR_SLEEP = 3'b000,
    SSC_PWR_ENTERING = 3'b001,
    SSC_PWR_DIAG = 3'b010,
    SSC_PWR_LOADING = 3'b011,
    SSC_PWR_AWAKE = 3'b100
  } ssc_pwr_state_t;

  typedef enum logic [1:0] {
    SSC_RD_DUMMY = 2'b00,
    SSC_RD_STATUS = 2'b01,
    SSC_RD_DONE = 2'b10
  } ssc_rd_phase_t;

endpackage

`default_nettype wire

// [core/ssc_diag.sv]
// self-diagnostic result holder
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"

module ssc_diag (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic soft_clear,
  input wire logic read_done,
  input wire logic healthy,
  // result
  output logic [`SSC_DIAG_FIELD_W-1:0] diagnostic_result_field
);

  logic [`SSC_DIAG_FIELD_W-1:0] result_reg;
  logic [`SSC_DIAG_FIELD_W-1:0] result_next;

  always_comb begin
    result_next = result_reg;
    if (soft_clear) begin
      result_next = `SSC_DIAG_RST;
    end else if (read_done && healthy) begin
      result_next = ~result_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= `SSC_DIAG_RST;
    end else begin
      result_reg <= result_next;
    end
  end

  assign diagnostic_result_field = result_reg;

endmodule

`default_nettype wire

// [bench/ssc_status_chk.sv]
// concurrent checks on the status read and sleep control ports
`timescale 1ns/1ps
`default_nettype none
module ssc_status_chk #(
  parameter int unsigned SETTLE_CYCLES = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // host pins
  input wire logic command_param_select,
  input wire logic read_strobe_n,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  // events and pixels
  input wire logic inversion_active,
  input wire logic nmi_event,
  input wire logic [17:0] mem_pixel,
  input wire logic [17:0] disp_pixel,
  // power state
  input wire logic charge_pump_en,
  input wire logic osc_en,
  input wire logic scan_en,
  input wire logic sleeping,
  input wire logic diag_running,
  input wire logic defaults_load,
  input wire logic soft_reset_pulse
);
  localparam int SLO = SETTLE_CYCLES - 1;
  localparam int SHI = SETTLE_CYCLES + 2;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  oe_needs_read_a: assert property ($rose(host_data_oe) |->
    $past(!read_strobe_n, 2) && $past(command_param_select, 2)) else $error("drive without parameter read");
  read_byte_hold_a: assert property (host_data_oe && $past(host_data_oe, 2) |-> $stable(host_data_out))
    else $error("read byte changed mid read");
  run_enables_a: assert property (charge_pump_en == osc_en && scan_en == osc_en && sleeping == !osc_en)
    else $error("power enables disagree");
  wake_via_diag_a: assert property ($rose(osc_en) |-> diag_running)
    else $error("wake skipped diagnostic");
  diag_then_load_a: assert property ($rose(diag_running) |-> ##[SLO:SHI] defaults_load ##1 !defaults_load)
    else $error("default load not after settle");
  dark_in_sleep_a: assert property (sleeping && $past(sleeping) |-> disp_pixel == 18'h00000)
    else $error("pixels shown while asleep");
  pixel_path_a: assert property (osc_en && $past(osc_en) |->
    disp_pixel == ($past(inversion_active) ? ~$past(mem_pixel) : $past(mem_pixel))) else $error("pixel path wrong");
  soft_to_sleep_a: assert property (soft_reset_pulse |=> !soft_reset_pulse ##[0:1] sleeping)
    else $error("soft reset did not sleep");
  nmi_to_sleep_a: assert property (nmi_event |-> ##[1:2] sleeping)
    else $error("event did not sleep");
  cover property ($rose(diag_running));
  cover property (defaults_load);
  cover property (soft_reset_pulse);
endmodule
`default_nettype wire

// [bench/ssc_host_model.sv]
// host controller model driving the command pins
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model (
  // clock
  input wire logic core_clk,
  // command pins
  output logic command_param_select,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out
);
  initial begin
    command_param_select = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_data_in = 8'hA5;
  end
  task automatic wr(input logic [7:0] c);
    @(negedge core_clk);
    command_param_select = 1'b0;
    host_data_in = c;
    write_strobe_n = 1'b0;
    repeat (4) @(negedge core_clk);
    write_strobe_n = 1'b1;
    repeat (4) @(negedge core_clk);
    host_data_in = ~c;
  endtask
  task automatic rd(output logic [7:0] d);
    @(negedge core_clk);
    command_param_select = 1'b1;
    read_strobe_n = 1'b0;
    repeat (5) @(negedge core_clk);
    d = host_data_out;
    read_strobe_n = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic query(input logic [7:0] c, output logic [7:0] dummy, output logic [7:0] st);
    wr(c);
    rd(dummy);
    rd(st);
  endtask
  // power command, then the wait the host owes
  task automatic power(input logic [7:0] c, input int n);
    wr(c);
    repeat (n) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// [bench/ssc_top_bench.sv]
// self-checking bench for the status read and sleep control block
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"
module ssc_top_bench;
  logic core_clk, rst_n, command_param_select, read_strobe_n, write_strobe_n, host_data_oe;
  logic scroll_active, inversion_active, tear_output_enabled, tear_output_mode, diag_healthy, nmi_event;
  logic charge_pump_en, osc_en, scan_en, sleeping, diag_running, defaults_load, soft_reset_pulse;
  logic [7:0] host_data_in, host_data_out, d0, d1;
  logic [17:0] mem_pixel, disp_pixel;
  logic [3:0] dg;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int i;
  ssc_top #(.SETTLE_CYCLES(8), .LOAD_CYCLES(20)) dut (.core_clk, .rst_n, .command_param_select, .read_strobe_n,
    .write_strobe_n, .host_data_in, .host_data_out, .host_data_oe, .scroll_active, .inversion_active,
    .tear_output_enabled, .tear_output_mode, .diag_healthy, .nmi_event, .charge_pump_en, .osc_en, .scan_en,
    .sleeping, .diag_running, .defaults_load, .soft_reset_pulse, .mem_pixel, .disp_pixel);
  ssc_host_model host (.core_clk, .command_param_select, .read_strobe_n, .write_strobe_n, .host_data_in,
    .host_data_out);
  function automatic logic [7:0] img_byte(input logic s, input logic v);
    return {s, 1'b0, v, 5'h00};
  endfunction
  function automatic logic [7:0] sig_byte(input logic t, input logic m);
    return {t, m, 6'h00};
  endfunction
  task automatic chk_val(input string n, input logic [17:0] e, input logic [17:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic hard_reset;
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic wake;
    host.power(`SSC_CMD_LEAVE_SLEEP, 4);
    chk_bit("diag_running", 1'b1, diag_running);
    chk_bit("osc_en", 1'b1, osc_en);
    repeat (24) @(negedge core_clk);
    chk_bit("sleeping", 1'b0, sleeping);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count = fail_count + 1;
      end_of_test();
    end
  end
  initial begin
    {rst_n, scroll_active, inversion_active, tear_output_enabled, tear_output_mode, diag_healthy, nmi_event} = 7'h00;
    mem_pixel = 18'h00000;
    i = $urandom(52);
    hard_reset();
    chk_bit("sleeping", 1'b1, sleeping);
    host.query(`SSC_CMD_READ_IMAGE_MODE, d0, d1);
    chk_val("image", 8'h00, d1);
    host.query(`SSC_CMD_READ_SIGNAL_MODE, d0, d1);
    chk_val("signal", 8'h00, d1);
    for (i = 0; i < 8; i++) begin
      {scroll_active, inversion_active, tear_output_enabled, tear_output_mode} = (i < 2) ? {4{i[0]}} : 4'($urandom);
      host.query(`SSC_CMD_READ_IMAGE_MODE, d0, d1);
      chk_val("dummy", 8'h00, d0);
      chk_val("image", img_byte(scroll_active, inversion_active), d1);
      host.query(`SSC_CMD_READ_SIGNAL_MODE, d0, d1);
      chk_val("signal", sig_byte(tear_output_enabled, tear_output_mode), d1);
    end
    diag_healthy = 1'b1;
    dg = 4'h0;
    for (i = 0; i < 5; i++) begin
      if (i == 3) diag_healthy = 1'b0;
      host.query(`SSC_CMD_READ_DIAGNOSTIC_RESULT_FIELD, d0, d1);
      chk_val("diag", {dg, 4'h0}, d1);
      if (diag_healthy) dg = ~dg;
    end
    host.rd(d0);
    chk_val("extra read", 8'h00, d0);
    wake();
    host.power(`SSC_CMD_LEAVE_SLEEP, 8);
    chk_bit("diag_running", 1'b0, diag_running);
    chk_bit("sleeping", 1'b0, sleeping);
    for (i = 0; i < 4; i++) begin
      mem_pixel = 18'($urandom);
      inversion_active = i[0];
      @(negedge core_clk);
      chk_val("pixel", inversion_active ? ~mem_pixel : mem_pixel, disp_pixel);
    end
    host.power(`SSC_CMD_ENTER_SLEEP, 24);
    chk_bit("pump", 1'b0, charge_pump_en);
    host.power(`SSC_CMD_ENTER_SLEEP, 24);
    host.query(`SSC_CMD_READ_DIAGNOSTIC_RESULT_FIELD, d0, d1);
    chk_val("diag", 8'hF0, d1);
    chk_bit("sleeping", 1'b1, sleeping);
    wake();
    host.power(`SSC_CMD_SOFT_RESET, 8);
    chk_bit("sleeping", 1'b1, sleeping);
    diag_healthy = 1'b1;
    host.query(`SSC_CMD_READ_DIAGNOSTIC_RESULT_FIELD, d0, d1);
    chk_val("diag", 8'h00, d1);
    wake();
    nmi_event = 1'b1;
    @(negedge core_clk);
    nmi_event = 1'b0;
    repeat (3) @(negedge core_clk);
    chk_bit("sleeping", 1'b1, sleeping);
    hard_reset();
    host.query(`SSC_CMD_READ_DIAGNOSTIC_RESULT_FIELD, d0, d1);
    chk_val("diag", 8'h00, d1);
    end_of_test();
  end
endmodule
bind ssc_top ssc_status_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk (.core_clk, .rst_n, .command_param_select,
  .read_strobe_n, .host_data_out, .host_data_oe, .inversion_active, .nmi_event, .mem_pixel, .disp_pixel,
  .charge_pump_en, .osc_en, .scan_en, .sleeping, .diag_running, .defaults_load, .soft_reset_pulse);
`default_nettype wire
